/* File: periph_reset_pkg.sv */
// constants and types for the peripheral soft reset register block
package periph_reset_pkg;

   // bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int BE_W   = DATA_W / 8;

   // byte addresses of the registers
   localparam logic [ADDR_W-1:0] OFS_HOLD_CFG  = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_RST_CTRL0 = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_RST_STAT  = 4'h8;

   // reset bit positions in peripheral_reset_control_0
   localparam int NUM_BITS                 = 17;
   localparam int BIT_TWOWIRE_CTRL_RESET   = 16;
   localparam int BIT_SERIAL_PERIPH_RESET  = 13;
   localparam int BIT_ASYNC_SERIAL_ONE     = 12;
   localparam int BIT_ASYNC_SERIAL_ZERO    = 11;
   localparam int BIT_TIMER_THREE_RESET    = 8;
   localparam int BIT_TIMER_TWO_RESET      = 7;
   localparam int BIT_TIMER_ONE_RESET      = 6;
   localparam int BIT_TIMER_ZERO_RESET     = 5;
   localparam int BIT_PIN_PORT_ONE_RESET   = 3;
   localparam int BIT_PIN_PORT_ZERO_RESET  = 2;
   localparam int BIT_WATCHDOG_ZERO_RESET  = 1;
   localparam int BIT_DMA_RESET            = 0;

   // bits that carry a reset action; 15:14, 10:9 and 4 do not
   localparam logic [NUM_BITS-1:0] IMPL_MASK = 17'h139ef;
   localparam logic [NUM_BITS-1:0] CTRL_RESET_VAL = 17'h00000;

   // hold configuration register
   localparam int HOLD_W = 8;
   localparam logic [HOLD_W-1:0] HOLD_RESET_VAL = 8'h00;

   // status register layout
   localparam int STAT_ANY_BIT = 17;

   // least reset pulse on a peripheral, in ns, and its cycle count at clk_sys
   localparam int CLK_PERIOD_PS = 5000;
   localparam int RST_MIN_NS    = 100;
   localparam int RST_MIN_CYC   = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W         = 16;

   // bus handshake states
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b01,
      BUS_ANS  = 2'b10
   } bus_state_t;

endpackage

/* File: reset_seq_if.sv */
// carrier between the register front end and the reset pulse generator
`timescale 1ns/1ps
`default_nettype none
interface reset_seq_if #(
   parameter int N  = 17,
   parameter int CW = 16
);
   logic [N-1:0]  start;
   logic [CW-1:0] holdCycles;
   logic [N-1:0]  busy;
   logic [N-1:0]  done;

   modport ctrl
   (
      output start,
      output holdCycles,
      input  busy,
      input  done
   );

   modport seq
   (
      input  start,
      input  holdCycles,
      output busy,
      output done
   );
endinterface
`default_nettype wire

/* File: reset_pulse_gen.sv */
// per-peripheral reset pulse counters
`timescale 1ns/1ps
`default_nettype none
module reset_pulse_gen
   import periph_reset_pkg::*;
#(
   parameter int N  = NUM_BITS,
   parameter int CW = CNT_W
)
(
   // clock and reset
   input wire logic   clk_sys,
   input wire logic   rst,
   input wire logic   clkEn,
   // link to register front end
   reset_seq_if.seq   link
);

   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_chan
         logic [CW-1:0] cnt_r;

         // finishing in this cycle, so the control bit falls on the same edge as the line
         assign link.done[i] = link.busy[i] && (cnt_r <= CW'(1));

         // busy doubles as the peripheral's reset line
         always_ff @(posedge clk_sys or posedge rst)
         begin
            if (rst)
            begin
               cnt_r        <= '0;
               link.busy[i] <= 1'b0;
            end
            else if (clkEn)
            begin
               if (link.start[i])
               begin
                  // a new start wins over a finish in the same cycle
                  cnt_r        <= link.holdCycles;
                  link.busy[i] <= 1'b1;
               end
               else if (link.busy[i])
               begin
                  if (cnt_r <= CW'(1))
                  begin
                     link.busy[i] <= 1'b0;
                  end
                  else
                  begin
                     cnt_r <= cnt_r - CW'(1);
                  end
               end
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

/* File: periph_reset_ctrl.sv */
// peripheral soft reset register with Avalon-MM slave
//
// Notes on behaviour
// - writing one starts that module's reset only
// - bit reads one until reset completes
// - watchdog bit 1, timers 8-5, ports 3-2
// - DMA bit 0; 15:14,10:9,4 reserved
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module periph_reset_ctrl
   import periph_reset_pkg::*;
#(
   parameter int MIN_CYCLES = RST_MIN_CYC
)
(
   // clock, reset, enable
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                clkEn,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0]   address,
   input  wire logic                read,
   input  wire logic                write,
   input  wire logic [DATA_W-1:0]   writedata,
   input  wire logic [BE_W-1:0]     byteenable,
   output logic      [DATA_W-1:0]   readdata,
   output logic                     waitrequest,
   // per-peripheral reset lines, active high
   output logic      [NUM_BITS-1:0] periphRst
);

   reset_seq_if #(.N(NUM_BITS), .CW(CNT_W)) seqLink ();

   bus_state_t          busState_r;
   bus_state_t          busState_nxt;
   logic [NUM_BITS-1:0] ctrl_r;
   logic [HOLD_W-1:0]   extraHold_r;
   logic [DATA_W-1:0]   readdata_r;
   logic [DATA_W-1:0]   rdValue;
   logic [DATA_W-1:0]   laneMask;
   logic [NUM_BITS-1:0] startReq;
   logic                wrCommit;
   logic                reqSeen;

   // register selection, shared by read mux and write path
   function automatic logic hitReg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hitReg = (a == ofs);
   endfunction

   // byte enables widened to a bit mask
   genvar b;
   generate
      for (b = 0; b < BE_W; b++)
      begin : g_lane
         assign laneMask[b*8 +: 8] = {8{byteenable[b]}};
      end
   endgenerate

   // handshake: take in IDLE, answer one cycle later with waitrequest low
   // limitation: keep clkEn high across a transfer; a write answered while frozen is lost
   assign reqSeen  = (read || write) && (busState_r == BUS_IDLE);
   assign wrCommit = write && (busState_r == BUS_ANS);

   always_comb
   begin
      busState_nxt = busState_r;
      unique case (busState_r)
         BUS_IDLE:
         begin
            if (read || write)
            begin
               busState_nxt = BUS_ANS;
            end
         end
         BUS_ANS:
         begin
            busState_nxt = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         busState_r  <= BUS_IDLE;
         waitrequest <= 1'b1;
      end
      else if (clkEn)
      begin
         busState_r  <= busState_nxt;
         waitrequest <= !(busState_nxt == BUS_ANS);
      end
   end

   // read mux; unmapped addresses and reserved bits read zero
   always_comb
   begin
      rdValue = '0;
      if (hitReg(address, OFS_HOLD_CFG))
      begin
         rdValue[HOLD_W-1:0] = extraHold_r;
      end
      else if (hitReg(address, OFS_RST_CTRL0))
      begin
         rdValue[NUM_BITS-1:0] = ctrl_r & IMPL_MASK;
      end
      else if (hitReg(address, OFS_RST_STAT))
      begin
         rdValue[NUM_BITS-1:0] = seqLink.busy & IMPL_MASK;
         rdValue[STAT_ANY_BIT] = |(seqLink.busy & IMPL_MASK);
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         readdata_r <= '0;
      end
      else if (clkEn && reqSeen && read)
      begin
         readdata_r <= rdValue;
      end
   end

   assign readdata = readdata_r;

   // a one written to an implemented bit starts it; zeros and reserved bits do nothing
   always_comb
   begin
      startReq = '0;
      if (wrCommit && hitReg(address, OFS_RST_CTRL0))
      begin
         startReq = writedata[NUM_BITS-1:0] & laneMask[NUM_BITS-1:0] & IMPL_MASK;
         // already running and not finishing now: ignored, count is not stretched
         startReq = startReq & ~(ctrl_r & ~seqLink.done);
      end
   end

   assign seqLink.start      = clkEn ? startReq : '0;
   assign seqLink.holdCycles = CNT_W'(MIN_CYCLES) + CNT_W'(extraHold_r);

   // control bits: set by accepted write, cleared by hardware at completion; set wins
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r <= CTRL_RESET_VAL;
      end
      else if (clkEn)
      begin
         ctrl_r <= ((ctrl_r & ~seqLink.done) | startReq) & IMPL_MASK;
      end
   end

   // extra hold cycles added to the least reset pulse
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         extraHold_r <= HOLD_RESET_VAL;
      end
      else if (clkEn && wrCommit && hitReg(address, OFS_HOLD_CFG) && byteenable[0])
      begin
         extraHold_r <= writedata[HOLD_W-1:0];
      end
   end

   // bit positions per peripheral fixed by the package mask
   reset_pulse_gen #(
      .N  (NUM_BITS),
      .CW (CNT_W)
   ) u_pulse (
      .clk_sys (clk_sys),
      .rst     (rst),
      .clkEn   (clkEn),
      .link    (seqLink)
   );

   assign periphRst = seqLink.busy;

endmodule
`default_nettype wire

/* File: periph_reset_ctrl_properties.sv */
// assertion checker for the peripheral reset block
`timescale 1ns/1ps
`default_nettype none
module periph_reset_checker
   import periph_reset_pkg::*;
#(
   parameter int MIN_CYCLES = RST_MIN_CYC
)
(
   // clock and reset
   input wire logic                clk_sys,
   input wire logic                rst,
   input wire logic                clkEn,
   // bus
   input wire logic [ADDR_W-1:0]   address,
   input wire logic                read,
   input wire logic                write,
   input wire logic [DATA_W-1:0]   writedata,
   input wire logic [BE_W-1:0]     byteenable,
   input wire logic [DATA_W-1:0]   readdata,
   input wire logic                waitrequest,
   // reset lines
   input wire logic [NUM_BITS-1:0] periphRst
);
   logic [CNT_W-1:0] highCnt_r;
   logic             wrCtl;
   assign wrCtl = write && !waitrequest && clkEn && address == OFS_RST_CTRL0;
   // counts every cycle; valid only while clkEn stays high
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         highCnt_r <= '0;
      else
         highCnt_r <= periphRst[0] ? highCnt_r + 1'b1 : '0;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_start;
      wrCtl && byteenable == 4'hf |=> (periphRst & $past(writedata[16:0]) & IMPL_MASK)
         == ($past(writedata[16:0]) & IMPL_MASK);
   endproperty
   a_start: assert property (p_start) else $error("reset bit not started");
   property p_only;
      1'b1 |=> (periphRst & ~$past(periphRst) & ~($past(wrCtl) ? $past(writedata[16:0]) : 17'h0)) == 17'h0;
   endproperty
   a_only: assert property (p_only) else $error("reset started without a one");
   property p_hold;
      $fell(periphRst[0]) |-> highCnt_r >= MIN_CYCLES;
   endproperty
   a_hold: assert property (p_hold) else $error("reset pulse too short");
   property p_wdog;
      wrCtl && byteenable[0] && writedata[3:0] == 4'h2 |=> periphRst[1];
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog reset not on bit 1");
   property p_resv;
      (periphRst & ~IMPL_MASK) == 17'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved reset line active");
   property p_rdbk;
      read && !waitrequest && address == OFS_RST_CTRL0 |-> readdata == {15'h0, $past(periphRst)};
   endproperty
   a_rdbk: assert property (p_rdbk) else $error("control read differs from lines");
endmodule
bind periph_reset_ctrl periph_reset_checker #(.MIN_CYCLES(MIN_CYCLES)) periph_reset_checker_inst
   (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .periphRst(periphRst));
`default_nettype wire

/* File: periph_reset_ctrl_tb_top.sv */
// self-checking bench for the peripheral reset block
`timescale 1ns/1ps
`default_nettype none
module periph_reset_ctrl_tb_top;
   import periph_reset_pkg::*;
   localparam int MINC = 4;
   logic                clk_sys = 1'b0;
   logic                rst = 1'b1;
   logic                clkEn = 1'b1;
   logic [BE_W-1:0]     byteenable = 4'hf;
   logic [ADDR_W-1:0]   address = '0;
   logic                read = 1'b0;
   logic                write = 1'b0;
   logic [DATA_W-1:0]   writedata = '0;
   logic [DATA_W-1:0]   readdata;
   logic                waitrequest;
   logic [NUM_BITS-1:0] periphRst;
   logic [DATA_W-1:0]   rd;
   int                  n_fail = 0;
   int                  comparisons = 0;
   int                  bitPos [12] = '{16, 13, 12, 11, 8, 7, 6, 5, 3, 2, 1, 0};
   always #2.5 clk_sys = ~clk_sys;
   periph_reset_ctrl #(.MIN_CYCLES(MINC)) periph_reset_ctrl_inst
      (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .address(address), .read(read), .write(write),
       .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
       .periphRst(periphRst));
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wait_ans();
      int i;
      i = 0;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0)
      begin
         i++;
         if (i > 50)
         begin
            n_fail++;
            end_sim();
         end
         @(posedge clk_sys);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      wait_ans();
      write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rdw(input logic [ADDR_W-1:0] a);
      address <= a;
      read <= 1'b1;
      wait_ans();
      rd = readdata;
      read <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic t_map();
      foreach (bitPos[i])
      begin
         wr(OFS_RST_CTRL0, 32'h1 << bitPos[i]);
         check({15'h0, periphRst}, 32'h1 << bitPos[i]);
         rdw(OFS_RST_CTRL0);
         check(rd, 32'h1 << bitPos[i]);
         repeat (20)
            if (rd !== '0)
               rdw(OFS_RST_CTRL0);
         check(rd, '0);
         check({15'h0, periphRst}, '0);
      end
      $display("map test done");
   endtask
   task automatic t_misc();
      int n;
      rdw(OFS_RST_CTRL0);
      check(rd, '0);
      wr(OFS_RST_CTRL0, 32'h0000c610);
      check({15'h0, periphRst}, '0);
      rdw(OFS_RST_CTRL0);
      check(rd, '0);
      wr(OFS_RST_CTRL0, '0);
      check({15'h0, periphRst}, '0);
      // unmapped place still answers, reads zero
      wr(4'hc, 32'hffffffff);
      rdw(4'hc);
      check(rd, '0);
      wr(OFS_RST_CTRL0, 32'h1);
      n = 0;
      while (periphRst[0] === 1'b1 && n < 100)
      begin
         @(posedge clk_sys);
         n++;
      end
      check(n, MINC);
      $display("misc test done");
   endtask
   task automatic t_regs();
      int n;
      wr(OFS_HOLD_CFG, 32'h2);
      rdw(OFS_HOLD_CFG);
      check(rd, 32'h2);
      wr(OFS_RST_CTRL0, 32'h1);
      n = 0;
      while (periphRst[0] === 1'b1 && n < 100)
      begin
         @(posedge clk_sys);
         n++;
      end
      check(n, MINC + 2);
      wr(OFS_RST_CTRL0, 32'h8);
      rdw(OFS_RST_STAT);
      check(rd, 32'h20008);
      // lane 2 off: bit 16 must not start
      byteenable <= 4'hb;
      wr(OFS_RST_CTRL0, 32'h10000);
      check({15'h0, periphRst} & 32'h10000, '0);
      byteenable <= 4'hf;
      wr(OFS_HOLD_CFG, '0);
      $display("register test done");
   endtask
   task automatic t_freeze();
      int n;
      wr(OFS_RST_CTRL0, 32'h1);
      clkEn <= 1'b0;
      repeat (10) @(posedge clk_sys);
      check({15'h0, periphRst}, 32'h1);
      clkEn <= 1'b1;
      // frozen cycles do not count down the pulse
      n = 0;
      while (periphRst[0] === 1'b1 && n < 100)
      begin
         @(posedge clk_sys);
         n++;
      end
      check(n, MINC);
      $display("freeze test done");
   endtask
   task automatic t_rst();
      wr(OFS_RST_CTRL0, 32'h100);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check({15'h0, periphRst}, '0);
      check({31'h0, waitrequest}, 32'h1);
      rst <= 1'b0;
      @(posedge clk_sys);
      rdw(OFS_RST_CTRL0);
      check(rd, '0);
      $display("reset test done");
   endtask
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_misc();
      t_map();
      t_regs();
      t_freeze();
      t_rst();
      end_sim();
   end
endmodule
`default_nettype wire
